// >>> src/cct_pkg.sv
// Package for the CAN control register 0 status and timer block
package cct_pkg;
    // ------------------------------------------------------------
    // Register map (word offsets on Avalon-MM)
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL0    = 4'h0;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h1;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h2;
    localparam logic [3:0] OFF_TSTAMP   = 4'h3;
    localparam logic [3:0] OFF_TIMER    = 4'h4;
    localparam logic [3:0] OFF_STATUS   = 4'h5;

    // ------------------------------------------------------------
    // Control register 0 fields
    // ------------------------------------------------------------
    localparam int BIT_FRAME_RECEIVED_FLAG_F = 7;
    localparam int BIT_RECEIVER_ACTIVE_FLAG_F = 6;
    localparam int BIT_CSW_F   = 5;
    localparam int BIT_SYNC_F  = 4;
    localparam int BIT_TIME_F  = 3;
    localparam int BIT_WAKE_F  = 2;
    localparam int BIT_SLP_F   = 1;
    localparam int BIT_INIT_F  = 0;
    localparam logic [7:0] CTRL0_RESET = 8'h00;

    // Interrupt status bits
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_STAMP = 1;
    localparam int IRQ_SYNC  = 2;
    localparam int IRQ_W     = 3;

    // Recessive bits needed before the controller counts as synchronized
    localparam int          IDLE_BITS     = 11;
    localparam logic [3:0]  IDLE_BITS_CNT = 4'(IDLE_BITS);
    localparam logic [15:0] TIMER_RESET   = 16'h0000;

    // Events from the CAN core
    typedef struct packed {
        logic bit_tick;
        logic rx_bit;
        logic rx_active;
        logic tx_active;
        logic frame_ok;
        logic ack_seen;
        logic bus_off;
        logic loopback;
    } cct_core_t;

    // Timestamp write toward the message buffer
    typedef struct packed {
        logic        wr;
        logic [15:0] stamp;
    } cct_stamp_t;
endpackage : cct_pkg

// >>> src/cct_ctrl0.sv
// CAN control register 0, all eight bits, bit timer and timestamp capture
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1: Init mode holds register at reset
// RQ2: Writable again once init fully left
// RQ3: Writes outside init; init request always
// RQ4: Valid received frame sets frame flag
// RQ5: Frame flag cleared only by writing one
// RQ6: Frame/active flags meaningless in loopback
// RQ7: Receiver active while receiving, not transmitting
// RQ8: Stop-in-wait gates bus interface clocks
// RQ9: Only controller drives synchronized flag
// RQ10: Timer enable runs 16-bit bit counter
// RQ11: Acked message gets timestamp in buffer
// RQ12: Disabled timer clears counter
// RQ13: Timer enable forced low in init
// RQ14: Acknowledge init after request
// RQ15: Resync after eleven recessive bits
// RQ16: Wait or stop forces transmit recessive; code forces it on wait only while stop-in-wait is set
// RQ17: Writes to read-only flags ignored
// RQ18: Stamp is counter at acknowledge
module cct_ctrl0
    import cct_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // CAN core side
    input  wire cct_core_t   core_in,
    input  wire logic        tx_from_core,
    input  wire logic        cpu_wait,
    input  wire logic        cpu_stop,
    output logic             transmit_pin,
    output cct_stamp_t       stamp_out,
    // Mode outputs
    output logic             init_mode_acknowledge,
    output logic             bus_clk_gate_off,
    output logic             irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic        ack_q;
    logic        sync_q;
    logic [3:0]  idle_q;
    logic [15:0] timer_q;
    logic [15:0] stamp_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic        rd_pend_q;
    logic        gate_q;
    logic        tx_q;
    logic        irq_q;
    logic [31:0] rdata_q;
    logic        stwr_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // One register select, shared by every write strobe
    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] off);
        logic hit;
        hit = (a == off);
        return hit;
    endfunction

    wire         in_init  = ctrl_q[BIT_INIT_F] & ack_q;
    wire         gated    = ctrl_q[BIT_CSW_F] & cpu_wait;             // RQ8
    wire         acc      = (avs_read | avs_write) & ~gated;
    wire         wr_hit   = avs_write & acc & ~rd_pend_q;
    wire         wr_ctrl  = wr_hit & addr_is(avs_address, OFF_CTRL0);
    wire         wr_stat  = wr_hit & addr_is(avs_address, OFF_IRQ_STAT);
    wire         wr_mask  = wr_hit & addr_is(avs_address, OFF_IRQ_MASK);
    wire [7:0]   wd       = avs_writedata[7:0];
    wire         lb       = core_in.loopback;
    // Loopback makes receive status meaningless, so keep it quiet
    wire         frame_ev = core_in.frame_ok & ~lb & ~in_init;          // RQ4 RQ6
    wire         rx_act   = core_in.rx_active & ~core_in.tx_active & ~lb & ~in_init; // RQ7 RQ6
    wire         stamp_ev = ctrl_q[BIT_TIME_F] & core_in.ack_seen;     // RQ11
    wire         sync_ev  = ~sync_q & (idle_q == IDLE_BITS_CNT - 4'h1) & core_in.bit_tick & core_in.rx_bit;
    wire         clr_frm  = wr_ctrl & ~in_init & wd[BIT_FRAME_RECEIVED_FLAG_F];      // RQ5

    // Next value of the writable control bits
    logic [7:0] ctrl_d;
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d[BIT_INIT_F] = wd[BIT_INIT_F];                       // RQ3
            if (!in_init)                                              // RQ2 RQ3
            begin
                ctrl_d[BIT_CSW_F]  = wd[BIT_CSW_F];
                ctrl_d[BIT_TIME_F] = wd[BIT_TIME_F];
                ctrl_d[BIT_WAKE_F] = wd[BIT_WAKE_F];
                ctrl_d[BIT_SLP_F]  = wd[BIT_SLP_F];
            end
        end
        // Set wins over a same-cycle clear
        ctrl_d[BIT_FRAME_RECEIVED_FLAG_F] = frame_ev | (ctrl_q[BIT_FRAME_RECEIVED_FLAG_F] & ~clr_frm); // RQ4 RQ5
        ctrl_d[BIT_RECEIVER_ACTIVE_FLAG_F] = rx_act;                                  // RQ7 RQ17
        ctrl_d[BIT_SYNC_F]  = sync_q;                                  // RQ9 RQ17
        if (in_init)
        begin
            // Everything but wake, sleep and init request to reset
            ctrl_d[BIT_FRAME_RECEIVED_FLAG_F] = CTRL0_RESET[BIT_FRAME_RECEIVED_FLAG_F];            // RQ1
            ctrl_d[BIT_RECEIVER_ACTIVE_FLAG_F] = CTRL0_RESET[BIT_RECEIVER_ACTIVE_FLAG_F];            // RQ1
            ctrl_d[BIT_CSW_F]   = CTRL0_RESET[BIT_CSW_F];              // RQ1
            ctrl_d[BIT_SYNC_F]  = CTRL0_RESET[BIT_SYNC_F];             // RQ1
            ctrl_d[BIT_TIME_F]  = 1'b0;                                // RQ13
        end
    end

    // ------------------------------------------------------------
    // Register file and mode handshake
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q <= CTRL0_RESET;
            ack_q  <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            ack_q  <= ctrl_d[BIT_INIT_F];                              // RQ14
        end
    end

    // ------------------------------------------------------------
    // Bus synchronization
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_q <= 1'b0;
            idle_q <= 4'h0;
        end
        else if (in_init || ctrl_q[BIT_INIT_F] || core_in.bus_off)
        begin
            // Bus-off recovery is the core's job; stay unsynchronized
            sync_q <= 1'b0;
            idle_q <= 4'h0;
        end
        else if (!sync_q && core_in.bit_tick)
        begin
            if (sync_ev)
            begin
                sync_q <= 1'b1;                                        // RQ15 RQ9
            end
            idle_q <= core_in.rx_bit ? idle_q + 4'h1 : 4'h0;           // RQ15
        end
    end

    // ------------------------------------------------------------
    // Bit timer and timestamp
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timer_q <= TIMER_RESET;
        end
        else if (!ctrl_q[BIT_TIME_F])
        begin
            timer_q <= TIMER_RESET;                                    // RQ12
        end
        else if (core_in.bit_tick)
        begin
            timer_q <= timer_q + 16'h0001;                             // RQ10
        end
    end

    // Stamp keeps the count as it stood when the acknowledge came
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stamp_q <= TIMER_RESET;
            stwr_q  <= 1'b0;
        end
        else
        begin
            stwr_q <= stamp_ev;                                        // RQ11
            if (stamp_ev)
            begin
                stamp_q <= timer_q;                                    // RQ18
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [IRQ_W-1:0] ev_vec = {sync_ev, stamp_ev, frame_ev};
    wire [IRQ_W-1:0] clr_v  = wr_stat ? avs_writedata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] mask_d = wr_mask ? avs_writedata[IRQ_W-1:0] : mask_q;
    wire [IRQ_W-1:0] stat_d;

    genvar g;
    generate
        for (g = 0; g < IRQ_W; g++)
        begin : g_stat
            // Set wins over a same-cycle clear
            assign stat_d[g] = ev_vec[g] | (stat_q[g] & ~clr_v[g]);
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stat_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // Built from next values so irq moves with the status flops
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(stat_d & mask_d);
        end
    end

    // ------------------------------------------------------------
    // Bus answer and pins
    // ------------------------------------------------------------
    // Reads take one wait cycle so the data leaves a flip-flop
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            OFF_CTRL0:    rd_mux = {24'h000000, ctrl_q};
            OFF_IRQ_STAT: rd_mux = {29'h00000000, stat_q};
            OFF_IRQ_MASK: rd_mux = {29'h00000000, mask_q};
            OFF_TSTAMP:   rd_mux = {16'h0000, stamp_q};
            OFF_TIMER:    rd_mux = {16'h0000, timer_q};
            OFF_STATUS:   rd_mux = {30'h00000000, sync_q, ack_q};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    wire         rd_take  = avs_read & acc & ~rd_pend_q;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_pend_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            rd_pend_q <= rd_take;
            if (rd_take)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Gate follows wait only while stop-in-wait is set
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gate_q <= 1'b0;
        end
        else
        begin
            gate_q <= gated;                                           // RQ8
        end
    end

    // Recessive on wait-with-stop, stop, or init request
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_q <= 1'b1;
        end
        else
        begin
            tx_q <= gated | cpu_stop | ctrl_q[BIT_INIT_F] | tx_from_core; // RQ16
        end
    end

    assign avs_readdata          = rdata_q;
    assign avs_waitrequest       = ~(rd_pend_q | (avs_write & acc & ~rd_pend_q));
    assign transmit_pin          = tx_q;
    assign stamp_out             = '{wr: stwr_q, stamp: stamp_q};
    assign init_mode_acknowledge = ack_q;
    assign bus_clk_gate_off      = gate_q;
    assign irq                   = irq_q;
endmodule // cct_ctrl0

`default_nettype wire

// >>> bench/cct_ctrl0_checker.sv
// Port-level assertions for the control register status and timer block
`timescale 1ns/1ps
`default_nettype none
module cct_ctrl0_checker
    import cct_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // Register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // Core side
    input wire cct_core_t   core_in,
    input wire logic        cpu_wait,
    input wire logic        cpu_stop,
    input wire logic        transmit_pin,
    input wire cct_stamp_t  stamp_out,
    input wire logic        init_mode_acknowledge,
    input wire logic        bus_clk_gate_off
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic ctl_wr = avs_write && !avs_waitrequest && avs_address == OFF_CTRL0;
    wire logic awake  = !cpu_wait && !bus_clk_gate_off;
    sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
    property p_rd_wait; avs_read && awake && !$past(avs_read) |-> s_one_wait; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
    property p_wr_fast; avs_write && awake |-> !avs_waitrequest; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_stall; (avs_read || avs_write) && cpu_wait && bus_clk_gate_off |-> avs_waitrequest; endproperty
    a_stall: assert property (p_stall) else $error("bus answered while gated");
    property p_gate; bus_clk_gate_off |-> $past(cpu_wait); endproperty
    a_gate: assert property (p_gate) else $error("gated outside wait");
    property p_stop_rec; cpu_stop |=> transmit_pin; endproperty
    a_stop_rec: assert property (p_stop_rec) else $error("pin dominant in stop");
    property p_init_ack; ctl_wr && avs_writedata[BIT_INIT_F] |-> ##[1:3] init_mode_acknowledge; endproperty
    a_init_ack: assert property (p_init_ack) else $error("no init acknowledge");
    sequence s_leave; ctl_wr && !avs_writedata[BIT_INIT_F] && init_mode_acknowledge; endsequence
    property p_init_exit; s_leave |-> ##[1:3] !init_mode_acknowledge; endproperty
    a_init_exit: assert property (p_init_exit) else $error("init not left");
    property p_stamp; stamp_out.wr |-> $past(core_in.ack_seen); endproperty
    a_stamp: assert property (p_stamp) else $error("stamp without acknowledge");
endmodule // cct_ctrl0_checker
`default_nettype wire

// >>> bench/cct_can_model.sv
// Far-side bus model: bit ticks, idle recessive line, frames and acknowledges
`timescale 1ns/1ps
`default_nettype none
module cct_can_model
    import cct_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Scenario requests: bit 0 frame, bit 1 acknowledge
    input  wire logic [1:0] ev,
    input  wire logic       rx_act,
    input  wire logic       lb,
    // Toward the block
    output cct_core_t       core_in
);
    logic [1:0] div_q;
    logic [1:0] pend_q;
    wire logic  tick = div_q == 2'h3;
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            {div_q, pend_q} <= 4'h0;
        else
            {div_q, pend_q} <= {div_q + 2'h1, tick ? ev : (pend_q | ev)};
    end
    // Events only land on bit boundaries, as on a real bus
    assign core_in = '{tick, 1'b1, rx_act, 1'b0, tick & pend_q[0], tick & pend_q[1], 1'b0, lb};
endmodule // cct_can_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the control register status and timer block
`timescale 1ns/1ps
`default_nettype none
module tb_top import cct_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        tx_from_core = 1'b0;
    logic        cpu_wait = 1'b0;
    logic        cpu_stop = 1'b0;
    logic        rx_act = 1'b0;
    logic        lb = 1'b0;
    logic [1:0]  ev = 2'h0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [15:0] st_seen = 16'h0;
    logic [31:0] avs_readdata, rd_v;
    logic        avs_waitrequest, transmit_pin, init_mode_acknowledge, bus_clk_gate_off, irq;
    cct_core_t   core_in;
    cct_stamp_t  stamp_out;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    localparam logic [3:0] RA [5] = '{OFF_CTRL0, OFF_CTRL0, OFF_CTRL0, OFF_IRQ_MASK, 4'hF};
    localparam logic [7:0] RW [5] = '{8'hF0, 8'h08, 8'h00, 8'h01, 8'hFF};
    localparam logic [7:0] RX [5] = '{8'h30, 8'h18, 8'h10, 8'h01, 8'h00};
    cct_ctrl0 dut_u (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .core_in, .tx_from_core, .cpu_wait, .cpu_stop, .transmit_pin, .stamp_out,
        .init_mode_acknowledge, .bus_clk_gate_off, .irq);
    cct_can_model bus_u (.sys_clk, .sys_rst, .ev, .rx_act, .lb, .core_in);
    task automatic report_and_stop;
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        rd_v = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd_v, e);
    endtask
    task automatic ev_go(input logic [1:0] k);
        ev <= k;
        @(posedge sys_clk);
        ev <= 2'h0;
        repeat (12) @(posedge sys_clk);
    endtask
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (stamp_out.wr === 1'b1)
            st_seen <= stamp_out.stamp;
        if (cyc == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdc(OFF_CTRL0, 32'h00);
        repeat (60) @(posedge sys_clk);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, RA[i], 32'(RW[i]));
            rdc(RA[i], 32'(RX[i]));
        end
        bus(1'b1, OFF_IRQ_STAT, 32'hF);
        ev_go(2'h1);
        rdc(OFF_CTRL0, 32'h90);
        chk(32'(irq), 32'h1);
        bus(1'b1, OFF_CTRL0, 32'h00);
        rdc(OFF_CTRL0, 32'h90);
        bus(1'b1, OFF_CTRL0, 32'h80);
        rdc(OFF_CTRL0, 32'h10);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        bus(1'b1, OFF_IRQ_STAT, 32'h1);
        bus(1'b1, OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        rx_act <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rdc(OFF_CTRL0, 32'h50);
        rx_act <= 1'b0;
        lb     <= 1'b1;
        ev_go(2'h1);
        rdc(OFF_CTRL0, 32'h10);
        lb <= 1'b0;
        bus(1'b1, OFF_CTRL0, 32'h08);
        repeat (20) @(posedge sys_clk);
        ev_go(2'h2);
        rdc(OFF_TSTAMP, 32'(st_seen));
        chk(32'(st_seen != 16'h0), 32'h1);
        bus(1'b1, OFF_CTRL0, 32'h00);
        rdc(OFF_TIMER, 32'h0);
        bus(1'b1, OFF_CTRL0, 32'h28);
        bus(1'b1, OFF_CTRL0, 32'h01);
        while (init_mode_acknowledge !== 1'b1)
            @(posedge sys_clk);
        rdc(OFF_CTRL0, 32'h01);
        bus(1'b1, OFF_CTRL0, 32'h29);
        rdc(OFF_CTRL0, 32'h01);
        bus(1'b1, OFF_CTRL0, 32'h00);
        while (init_mode_acknowledge !== 1'b0)
            @(posedge sys_clk);
        bus(1'b1, OFF_CTRL0, 32'h08);
        rdc(OFF_CTRL0, 32'h08);
        repeat (60) @(posedge sys_clk);
        rdc(OFF_CTRL0, 32'h18);
        chk(32'(transmit_pin), 32'h0);
        bus(1'b1, OFF_CTRL0, 32'h20);
        cpu_wait <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'(bus_clk_gate_off), 32'h1);
        chk(32'(transmit_pin), 32'h1);
        fork
            rdc(OFF_CTRL0, 32'h30);
            begin
                repeat (4) @(posedge sys_clk);
                cpu_wait <= 1'b0;
            end
        join
        cpu_stop <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'(transmit_pin), 32'h1);
        report_and_stop();
    end
endmodule // tb_top
bind cct_ctrl0 cct_ctrl0_checker chk_u (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_waitrequest, .core_in, .cpu_wait, .cpu_stop, .transmit_pin, .stamp_out,
    .init_mode_acknowledge, .bus_clk_gate_off);
`default_nettype wire
